// *** logic/lpqm_top.sv ***
// top: zero crossing, timeout, period/frequency, sag and peak monitoring with register port
//
// Function
// - zero crossing from filter, bypass selectable
// - crossing sets status bit 0, interrupt
// - 12-bit timeout decrements every 160 clocks
// - timeout reloads at crossing, resets fff
// - timeout zero sets bit 1, interrupt
// - timeout value readable and writable
// - 16-bit period or frequency per period
// - period counted at master clock / 10
// - frequency at 1/16 Hz per count
// - sag while magnitude below threshold
// - threshold 0 or 1 means level zero
// - cycle count is one plus cycles
// - sag sets power flag bit 5, interrupt
// - voltage peak above threshold sets bit 3
// - current top bytes above threshold set bit 4
// - peak interrupts gated by enable bits
// - 24-bit peak holds track the maximum
// - clear-on-read alias returns then zeroes hold
`timescale 1ns/10ps
module lpqm_top #(
	parameter int SAMPLE_W = 24,
	parameter int FILT_W = 16
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic metering_clk_en_i,
	input wire logic voltage_valid_i,
	input wire logic signed [SAMPLE_W-1:0] voltage_sample_i,
	input wire logic current_valid_i,
	input wire logic signed [SAMPLE_W-1:0] current_sample_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [23:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [23:0] reg_rdata_o,
	output logic energy_irq_o,
	output logic power_mgmt_irq_o,
	output logic line_crossing_o
);
	// ****************************************************************
	// sample conditioning
	// ****************************************************************
	logic signed [FILT_W-1:0] volt_top;
	logic signed [FILT_W-1:0] cur_top;
	logic signed [FILT_W+lpqm_pkg::LOWPASS_SHIFT-1:0] lpf_acc;
	logic signed [FILT_W+lpqm_pkg::LOWPASS_SHIFT-1:0] next_lpf_acc;
	logic signed [FILT_W-1:0] lpf_out;
	logic signed [FILT_W-1:0] zx_input;
	logic zx_sign;
	logic next_zx_sign;
	logic zx_event;
	logic [7:0] mode_register_two;
	logic [7:0] filter_control;

	assign volt_top = voltage_sample_i[SAMPLE_W-1 -: FILT_W];
	assign cur_top = current_sample_i[SAMPLE_W-1 -: FILT_W];
	assign lpf_out = lpf_acc[FILT_W+lpqm_pkg::LOWPASS_SHIFT-1 -: FILT_W];
	// bypass trades noise rejection for lower group delay
	assign zx_input = filter_control[lpqm_pkg::BIT_FILTER_BYPASS] ? volt_top : lpf_out;

	always_comb begin
		next_lpf_acc = lpf_acc;
		next_zx_sign = zx_sign;
		if (voltage_valid_i) begin
			next_lpf_acc = lpf_acc + (FILT_W+lpqm_pkg::LOWPASS_SHIFT)'(volt_top)
				- (FILT_W+lpqm_pkg::LOWPASS_SHIFT)'(lpf_out);
			next_zx_sign = zx_input[FILT_W-1];
		end
	end
	// only negative-to-positive transitions count, one per line period
	assign zx_event = voltage_valid_i && zx_sign && !zx_input[FILT_W-1];

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lpf_acc <= '0;
			zx_sign <= 1'b0;
		end else begin
			lpf_acc <= next_lpf_acc;
			zx_sign <= next_zx_sign;
		end
	end

	lpqm_abs_if #(.W(FILT_W)) zx_abs_bus();
	lpqm_abs_if #(.W(FILT_W)) cur_abs_bus();
	lpqm_abs_if #(.W(SAMPLE_W)) vhold_abs_bus();
	lpqm_abs_if #(.W(SAMPLE_W)) ihold_abs_bus();
	assign zx_abs_bus.sample = zx_input;
	assign cur_abs_bus.sample = cur_top;
	assign vhold_abs_bus.sample = voltage_sample_i;
	assign ihold_abs_bus.sample = current_sample_i;
	lpqm_abs u_zx_abs (.port(zx_abs_bus.unit));
	lpqm_abs u_cur_abs (.port(cur_abs_bus.unit));
	lpqm_abs u_vhold_abs (.port(vhold_abs_bus.unit));
	lpqm_abs u_ihold_abs (.port(ihold_abs_bus.unit));

	// ****************************************************************
	// clock dividers from the metering clock enable
	// ****************************************************************
	logic [7:0] div160;
	logic [7:0] next_div160;
	logic [3:0] div10;
	logic [3:0] next_div10;
	logic tick160;
	logic tick10;
	assign tick160 = metering_clk_en_i && (div160 == 8'(lpqm_pkg::TIMEOUT_TICK_MCLK - 1));
	assign tick10 = metering_clk_en_i && (div10 == 4'(lpqm_pkg::PERIOD_TICK_MCLK - 1));
	always_comb begin
		next_div160 = div160;
		next_div10 = div10;
		if (metering_clk_en_i) begin
			next_div160 = tick160 ? 8'h00 : div160 + 8'h01;
			next_div10 = tick10 ? 4'h0 : div10 + 4'h1;
		end
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div160 <= 8'h00;
			div10 <= 4'h0;
		end else begin
			div160 <= next_div160;
			div10 <= next_div10;
		end
	end

	// ****************************************************************
	// registers written by software
	// ****************************************************************
	logic [11:0] crossing_timeout_value;
	logic [7:0] sag_cycle_count;
	logic [15:0] sag_threshold;
	logic [15:0] current_peak_threshold;
	logic [15:0] voltage_peak_threshold;
	logic [7:0] energy_irq_enable_three;
	logic [7:0] power_mgmt_irq_enable;
	logic wr_ctl;
	assign wr_ctl = reg_wr_i;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			crossing_timeout_value <= lpqm_pkg::RST_CROSSING_TIMEOUT_VALUE;
			sag_cycle_count <= lpqm_pkg::RST_SAG_CYCLE_COUNT;
			sag_threshold <= lpqm_pkg::RST_SAG_THRESHOLD;
			current_peak_threshold <= lpqm_pkg::RST_PEAK_THRESHOLD;
			voltage_peak_threshold <= lpqm_pkg::RST_PEAK_THRESHOLD;
			energy_irq_enable_three <= 8'h00;
			power_mgmt_irq_enable <= 8'h00;
			mode_register_two <= lpqm_pkg::RST_MODE_REGISTER_TWO;
			filter_control <= 8'h00;
		end else if (wr_ctl) begin
			unique case (reg_addr_i)
				lpqm_pkg::ADDR_CROSSING_TIMEOUT_VALUE: crossing_timeout_value <= reg_wdata_i[11:0];
				lpqm_pkg::ADDR_SAG_CYCLE_COUNT: sag_cycle_count <= reg_wdata_i[7:0];
				lpqm_pkg::ADDR_SAG_THRESHOLD: sag_threshold <= reg_wdata_i[15:0];
				lpqm_pkg::ADDR_CURRENT_PEAK_THRESHOLD: current_peak_threshold <= reg_wdata_i[15:0];
				lpqm_pkg::ADDR_VOLTAGE_PEAK_THRESHOLD: voltage_peak_threshold <= reg_wdata_i[15:0];
				lpqm_pkg::ADDR_ENERGY_IRQ_ENABLE_THREE: energy_irq_enable_three <= reg_wdata_i[7:0];
				lpqm_pkg::ADDR_POWER_MGMT_IRQ_ENABLE: power_mgmt_irq_enable <= reg_wdata_i[7:0];
				lpqm_pkg::ADDR_MODE_REGISTER_TWO: mode_register_two <= reg_wdata_i[7:0];
				lpqm_pkg::ADDR_FILTER_CONTROL: filter_control <= reg_wdata_i[7:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// timeout, period and frequency
	// ****************************************************************
	logic [11:0] timeout_cnt;
	logic [11:0] next_timeout_cnt;
	logic timeout_hit;
	logic timeout_armed;
	logic next_timeout_armed;
	logic [15:0] period_cnt;
	logic [15:0] next_period_cnt;
	logic [15:0] line_period_or_frequency;
	logic [15:0] next_line_period_or_frequency;
	logic [31:0] freq_value;
	// divider is combinational; fine at this low event rate
	assign freq_value = (period_cnt == 16'h0000) ? 32'h0000_0000 : lpqm_pkg::FREQ_NUMERATOR / {16'h0000, period_cnt};
	assign timeout_hit = tick160 && timeout_armed && (timeout_cnt == 12'h001);

	always_comb begin
		next_timeout_cnt = timeout_cnt;
		next_timeout_armed = timeout_armed;
		next_period_cnt = period_cnt;
		next_line_period_or_frequency = line_period_or_frequency;
		if (zx_event) begin
			next_timeout_cnt = crossing_timeout_value;
			next_timeout_armed = 1'b1;
			next_period_cnt = 16'h0000;
			if (mode_register_two[lpqm_pkg::BIT_PERIOD_FREQUENCY_SELECT]) begin
				next_line_period_or_frequency = freq_value[15:0];
			end else begin
				next_line_period_or_frequency = period_cnt;
			end
		end else begin
			if (tick160 && timeout_armed) begin
				next_timeout_cnt = timeout_cnt - 12'h001;
				// one timeout per silence; rearmed by the next crossing
				if (timeout_hit) begin
					next_timeout_armed = 1'b0;
				end
			end
			if (tick10 && period_cnt != 16'hffff) begin
				next_period_cnt = period_cnt + 16'h0001;
			end
		end
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			timeout_cnt <= lpqm_pkg::RST_CROSSING_TIMEOUT_VALUE;
			timeout_armed <= 1'b1;
			period_cnt <= 16'h0000;
			line_period_or_frequency <= 16'h0000;
		end else begin
			timeout_cnt <= next_timeout_cnt;
			timeout_armed <= next_timeout_armed;
			period_cnt <= next_period_cnt;
			line_period_or_frequency <= next_line_period_or_frequency;
		end
	end

	// ****************************************************************
	// sag detection
	// ****************************************************************
	logic sag_below;
	logic [7:0] sag_cycles;
	logic [7:0] next_sag_cycles;
	logic sag_hit;
	logic sag_cycle_below;
	logic next_sag_cycle_below;
	// thresholds of 0 and 1 compare as zero so nothing is ever below
	assign sag_below = (sag_threshold > 16'h0001) && (zx_abs_bus.magnitude < sag_threshold);
	// count saturates; flag fires when count reaches programmed value minus one
	assign sag_hit = zx_event && sag_cycle_below && (8'(sag_cycles + 8'h01) == 8'(sag_cycle_count - 8'h01));
	always_comb begin
		next_sag_cycles = sag_cycles;
		next_sag_cycle_below = sag_cycle_below;
		if (voltage_valid_i && !sag_below) begin
			next_sag_cycle_below = 1'b0;
			next_sag_cycles = 8'h00;
		end
		if (zx_event) begin
			// a full cycle counts only if every sample in it was below
			if (sag_cycle_below && !(voltage_valid_i && !sag_below) && sag_cycles != 8'hff) begin
				next_sag_cycles = sag_cycles + 8'h01;
			end
			next_sag_cycle_below = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sag_cycles <= 8'h00;
			sag_cycle_below <= 1'b0;
		end else begin
			sag_cycles <= next_sag_cycles;
			sag_cycle_below <= next_sag_cycle_below;
		end
	end

	// ****************************************************************
	// peaks, holds and flags
	// ****************************************************************
	logic volt_peak_hit;
	logic cur_peak_hit;
	logic [23:0] voltage_peak_hold;
	logic [23:0] current_peak_hold;
	logic [23:0] next_voltage_peak_hold;
	logic [23:0] next_current_peak_hold;
	logic [7:0] energy_irq_status_three;
	logic [7:0] power_mgmt_irq_flags;
	logic [7:0] next_energy_irq_status_three;
	logic [7:0] next_power_mgmt_irq_flags;
	logic [7:0] energy_set;
	logic [7:0] power_set;
	logic rd_vclr;
	logic rd_iclr;

	// raw sample, not the filter output: a peak must not be smoothed away
	assign volt_peak_hit = voltage_valid_i && (vhold_abs_bus.magnitude[SAMPLE_W-1 -: FILT_W] > voltage_peak_threshold);
	assign cur_peak_hit = current_valid_i && (cur_abs_bus.magnitude > current_peak_threshold);
	assign rd_vclr = reg_rd_i && reg_addr_i == lpqm_pkg::ADDR_VOLTAGE_PEAK_HOLD_CLEAR_ON_READ;
	assign rd_iclr = reg_rd_i && reg_addr_i == lpqm_pkg::ADDR_CURRENT_PEAK_HOLD_CLEAR_ON_READ;

	always_comb begin
		energy_set = 8'h00;
		energy_set[lpqm_pkg::BIT_LINE_CROSSING] = zx_event;
		energy_set[lpqm_pkg::BIT_CROSSING_TIMEOUT] = timeout_hit;
		energy_set[lpqm_pkg::BIT_VOLTAGE_PEAK] = volt_peak_hit;
		energy_set[lpqm_pkg::BIT_CURRENT_PEAK] = cur_peak_hit;
		power_set = 8'h00;
		power_set[lpqm_pkg::BIT_SAG_EVENT] = sag_hit;
		next_energy_irq_status_three = energy_irq_status_three;
		next_power_mgmt_irq_flags = power_mgmt_irq_flags;
		// write-one-to-clear; a same-cycle event wins over the clear
		if (reg_wr_i && reg_addr_i == lpqm_pkg::ADDR_ENERGY_IRQ_STATUS_THREE) begin
			next_energy_irq_status_three = energy_irq_status_three & ~reg_wdata_i[7:0];
		end
		if (reg_wr_i && reg_addr_i == lpqm_pkg::ADDR_POWER_MGMT_IRQ_FLAGS) begin
			next_power_mgmt_irq_flags = power_mgmt_irq_flags & ~reg_wdata_i[7:0];
		end
		next_energy_irq_status_three = next_energy_irq_status_three | energy_set;
		next_power_mgmt_irq_flags = next_power_mgmt_irq_flags | power_set;

		next_voltage_peak_hold = rd_vclr ? 24'h000000 : voltage_peak_hold;
		next_current_peak_hold = rd_iclr ? 24'h000000 : current_peak_hold;
		if (voltage_valid_i && vhold_abs_bus.magnitude > next_voltage_peak_hold) begin
			next_voltage_peak_hold = vhold_abs_bus.magnitude;
		end
		if (current_valid_i && ihold_abs_bus.magnitude > next_current_peak_hold) begin
			next_current_peak_hold = ihold_abs_bus.magnitude;
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			energy_irq_status_three <= 8'h00;
			power_mgmt_irq_flags <= 8'h00;
			voltage_peak_hold <= 24'h000000;
			current_peak_hold <= 24'h000000;
			energy_irq_o <= 1'b0;
			power_mgmt_irq_o <= 1'b0;
			line_crossing_o <= 1'b0;
		end else begin
			energy_irq_status_three <= next_energy_irq_status_three;
			power_mgmt_irq_flags <= next_power_mgmt_irq_flags;
			voltage_peak_hold <= next_voltage_peak_hold;
			current_peak_hold <= next_current_peak_hold;
			energy_irq_o <= |(next_energy_irq_status_three & energy_irq_enable_three);
			power_mgmt_irq_o <= |(next_power_mgmt_irq_flags & power_mgmt_irq_enable);
			line_crossing_o <= zx_event;
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	logic [23:0] next_reg_rdata;
	always_comb begin
		next_reg_rdata = 24'h000000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				lpqm_pkg::ADDR_LINE_PERIOD_OR_FREQUENCY: next_reg_rdata = {8'h00, line_period_or_frequency};
				lpqm_pkg::ADDR_MODE_REGISTER_TWO: next_reg_rdata = {16'h0000, mode_register_two};
				lpqm_pkg::ADDR_CROSSING_TIMEOUT_VALUE: next_reg_rdata = {12'h000, crossing_timeout_value};
				lpqm_pkg::ADDR_SAG_CYCLE_COUNT: next_reg_rdata = {16'h0000, sag_cycle_count};
				lpqm_pkg::ADDR_SAG_THRESHOLD: next_reg_rdata = {8'h00, sag_threshold};
				lpqm_pkg::ADDR_CURRENT_PEAK_THRESHOLD: next_reg_rdata = {8'h00, current_peak_threshold};
				lpqm_pkg::ADDR_VOLTAGE_PEAK_THRESHOLD: next_reg_rdata = {8'h00, voltage_peak_threshold};
				lpqm_pkg::ADDR_CURRENT_PEAK_HOLD,
				lpqm_pkg::ADDR_CURRENT_PEAK_HOLD_CLEAR_ON_READ: next_reg_rdata = current_peak_hold;
				lpqm_pkg::ADDR_VOLTAGE_PEAK_HOLD,
				lpqm_pkg::ADDR_VOLTAGE_PEAK_HOLD_CLEAR_ON_READ: next_reg_rdata = voltage_peak_hold;
				lpqm_pkg::ADDR_ENERGY_IRQ_ENABLE_THREE: next_reg_rdata = {16'h0000, energy_irq_enable_three};
				lpqm_pkg::ADDR_ENERGY_IRQ_STATUS_THREE: next_reg_rdata = {16'h0000, energy_irq_status_three};
				lpqm_pkg::ADDR_POWER_MGMT_IRQ_ENABLE: next_reg_rdata = {16'h0000, power_mgmt_irq_enable};
				lpqm_pkg::ADDR_POWER_MGMT_IRQ_FLAGS: next_reg_rdata = {16'h0000, power_mgmt_irq_flags};
				lpqm_pkg::ADDR_FILTER_CONTROL: next_reg_rdata = {16'h0000, filter_control};
				default: next_reg_rdata = 24'h000000;
			endcase
		end
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 24'h000000;
		end else begin
			reg_rdata_o <= next_reg_rdata;
		end
	end
endmodule

// *** logic/lpqm_pkg.sv ***
// package: register map, field positions, reset values and timing constants for the power-quality monitor
package lpqm_pkg;
	// register offsets (byte addresses of the internal map)
	localparam logic [7:0] ADDR_LINE_PERIOD_OR_FREQUENCY = 8'h0a;
	localparam logic [7:0] ADDR_MODE_REGISTER_TWO = 8'h0c;
	localparam logic [7:0] ADDR_CROSSING_TIMEOUT_VALUE = 8'h11;
	localparam logic [7:0] ADDR_SAG_CYCLE_COUNT = 8'h13;
	localparam logic [7:0] ADDR_SAG_THRESHOLD = 8'h14;
	localparam logic [7:0] ADDR_CURRENT_PEAK_THRESHOLD = 8'h15;
	localparam logic [7:0] ADDR_VOLTAGE_PEAK_THRESHOLD = 8'h16;
	localparam logic [7:0] ADDR_CURRENT_PEAK_HOLD = 8'h17;
	localparam logic [7:0] ADDR_CURRENT_PEAK_HOLD_CLEAR_ON_READ = 8'h18;
	localparam logic [7:0] ADDR_VOLTAGE_PEAK_HOLD = 8'h19;
	localparam logic [7:0] ADDR_VOLTAGE_PEAK_HOLD_CLEAR_ON_READ = 8'h1a;
	localparam logic [7:0] ADDR_ENERGY_IRQ_ENABLE_THREE = 8'hdb;
	localparam logic [7:0] ADDR_ENERGY_IRQ_STATUS_THREE = 8'hde;
	localparam logic [7:0] ADDR_POWER_MGMT_IRQ_ENABLE = 8'hec;
	localparam logic [7:0] ADDR_POWER_MGMT_IRQ_FLAGS = 8'hf8;
	localparam logic [7:0] ADDR_FILTER_CONTROL = 8'h30;

	// field positions
	localparam int BIT_LINE_CROSSING = 0;
	localparam int BIT_CROSSING_TIMEOUT = 1;
	localparam int BIT_VOLTAGE_PEAK = 3;
	localparam int BIT_CURRENT_PEAK = 4;
	localparam int BIT_SAG_EVENT = 5;
	localparam int BIT_PERIOD_FREQUENCY_SELECT = 1;
	localparam int BIT_FILTER_BYPASS = 0;

	// reset values
	localparam logic [11:0] RST_CROSSING_TIMEOUT_VALUE = 12'hfff;
	localparam logic [7:0] RST_SAG_CYCLE_COUNT = 8'hff;
	localparam logic [15:0] RST_SAG_THRESHOLD = 16'h0000;
	localparam logic [15:0] RST_PEAK_THRESHOLD = 16'hffff;
	localparam logic [7:0] RST_MODE_REGISTER_TWO = 8'h00;

	// timing: nominal metering clock and its derived tick rates
	localparam int NOMINAL_MCLK_HZ = 4096000;
	localparam int TIMEOUT_TICK_MCLK = 160;
	localparam int PERIOD_TICK_MCLK = 10;
	localparam int FREQ_LSB_PER_HZ = 16;
	// numerator for frequency = NOMINAL/PERIOD_TICK * 16 / period_count
	localparam logic [31:0] FREQ_NUMERATOR = 32'(NOMINAL_MCLK_HZ / PERIOD_TICK_MCLK * FREQ_LSB_PER_HZ);
	// single-pole filter shift: pole near 63.7 Hz at the filter's sample rate
	localparam int LOWPASS_SHIFT = 4;
endpackage

// *** logic/lpqm_abs_if.sv ***
// interface: one signed sample in, its magnitude out
`timescale 1ns/10ps
interface lpqm_abs_if #(parameter int W = 24);
	logic signed [W-1:0] sample;
	logic [W-1:0] magnitude;
	modport user (output sample, input magnitude);
	modport unit (input sample, output magnitude);
endinterface

// *** logic/lpqm_abs.sv ***
// module: saturating absolute value of a signed sample
`timescale 1ns/10ps
module lpqm_abs (
	lpqm_abs_if.unit port
);
	localparam int W = $bits(port.sample);
	logic [W-1:0] negated;
	always_comb begin
		negated = W'(-port.sample);
		// most negative code saturates instead of wrapping to itself
		if (port.sample[W-1] && negated[W-1]) begin
			port.magnitude = {1'b0, {(W-1){1'b1}}};
		end else if (port.sample[W-1]) begin
			port.magnitude = negated;
		end else begin
			port.magnitude = port.sample;
		end
	end
endmodule

// *** verif/lpqm_top_assertions.sv ***
// checker: port-level properties of the power-quality monitor
`timescale 1ns/10ps
module lpqm_top_assertions (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic metering_clk_en_i,
	input wire logic voltage_valid_i,
	input wire logic current_valid_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [23:0] reg_rdata_o,
	input wire logic energy_irq_o,
	input wire logic power_mgmt_irq_o,
	input wire logic line_crossing_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 24'h0)
		else $error("read data not zero outside a read answer");
	unmapped_read_a: assert property (reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o == 24'h0)
		else $error("unmapped read not zero");
	crossing_pulse_a: assert property (line_crossing_o |=> !line_crossing_o)
		else $error("crossing pulse longer than one cycle");
	crossing_cause_a: assert property (line_crossing_o |-> $past(voltage_valid_i) || $past(voltage_valid_i, 2))
		else $error("crossing without a voltage sample");
	energy_rise_a: assert property ($rose(energy_irq_o) |-> $past(reg_wr_i) || $past(voltage_valid_i)
		|| $past(current_valid_i) || $past(metering_clk_en_i))
		else $error("energy request rose without cause");
	energy_hold_a: assert property ($fell(energy_irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
		else $error("energy request dropped without a write");
	pm_rise_a: assert property ($rose(power_mgmt_irq_o) |-> line_crossing_o || $past(line_crossing_o)
		|| $past(reg_wr_i))
		else $error("power request rose away from a crossing");
	pm_hold_a: assert property ($fell(power_mgmt_irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
		else $error("power request dropped without a write");
	clear_read_a: assert property ((reg_rd_i && reg_addr_i == 8'h1a && !voltage_valid_i) ##1
		!voltage_valid_i ##1 (reg_rd_i && reg_addr_i == 8'h19) |=> reg_rdata_o == 24'h0)
		else $error("voltage hold not cleared by its alias read");
	hold_read_a: assert property ((reg_rd_i && reg_addr_i == 8'h17 && !current_valid_i) ##1
		!current_valid_i ##1 (reg_rd_i && reg_addr_i == 8'h17) |=> reg_rdata_o == $past(reg_rdata_o, 2))
		else $error("current hold changed by a plain read");
endmodule

// *** verif/lpqm_core_model.sv ***
// processor-core model: drives the register port as the embedded core does
`timescale 1ns/10ps
module lpqm_core_model (
	input wire logic clk_i,
	input wire logic [23:0] rdata_i,
	output logic [7:0] addr_o,
	output logic [23:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 24'h000000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// stale data must not look valid once the strobe is gone
		wdata_o <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		// answer stands only in the cycle after the strobe
		#1;
		d = rdata_i;
	endtask
endmodule

// *** verif/lpqm_top_tb.sv ***
// testbench: register-level scenarios for the power-quality monitor
`timescale 1ns/10ps
module lpqm_top_tb;
	logic clk;
	logic rst;
	logic men;
	logic vval;
	logic signed [23:0] vsmp;
	logic ival;
	logic signed [23:0] ismp;
	logic [7:0] addr;
	logic [23:0] wdata;
	logic wr;
	logic rd;
	logic [23:0] rdata;
	logic eirq;
	logic pirq;
	logic zc;
	logic [23:0] d;
	int err_total;
	int n_checks;

	lpqm_top DUT (.sys_clk_i(clk), .sys_rst_i(rst), .metering_clk_en_i(men), .voltage_valid_i(vval),
		.voltage_sample_i(vsmp), .current_valid_i(ival), .current_sample_i(ismp), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .energy_irq_o(eirq),
		.power_mgmt_irq_o(pirq), .line_crossing_o(zc));
	lpqm_core_model CORE (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic end_of_test();
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [23:0] mask, input logic [23:0] exp);
		CORE.rd(a, d);
		chk(d & mask, exp);
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic smp(input logic signed [23:0] v, input logic signed [23:0] c);
		@(posedge clk);
		vval <= 1'b1;
		ival <= 1'b1;
		vsmp <= v;
		ismp <= c;
		@(posedge clk);
		vval <= 1'b0;
		ival <= 1'b0;
	endtask

	// n line cycles: negative half then positive half, a sample every 10 clocks
	task automatic cyc(input logic signed [23:0] amp, input int half, input int n);
		repeat (n) begin
			for (int i = 0; i < 2 * half; i++) begin
				@(posedge clk);
				vval <= (i % 10 == 0);
				vsmp <= (i < half) ? -amp : amp;
			end
		end
	endtask

	initial begin
		repeat (50000) @(posedge clk);
		err_total++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		men = 1'b1;
		vval = 1'b0;
		ival = 1'b0;
		vsmp = 24'sh000000;
		ismp = 24'sh000000;
		err_total = 0;
		n_checks = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc(8'h11, 24'hffffff, 24'h000fff);
		CORE.wr(8'h11, 24'h0005a5);
		rc(8'h11, 24'hffffff, 24'h0005a5);
		CORE.wr(8'h0a, 24'h001234);
		rc(8'h0a, 24'hffffff, 24'h000000);
		rc(8'h40, 24'hffffff, 24'h000000);
		// ****************************************
		// peaks and peak holds
		// ****************************************
		CORE.wr(8'h16, 24'h001000);
		CORE.wr(8'h15, 24'h002000);
		CORE.wr(8'hdb, 24'h000018);
		smp(24'sh100000, 24'sh200000);
		rc(8'hde, 24'hffffff, 24'h000000);
		smp(24'sh200000, -24'sh300000);
		settle();
		chk(eirq, 24'h1);
		rc(8'hde, 24'hffffff, 24'h000018);
		rc(8'h19, 24'hffffff, 24'h200000);
		rc(8'h17, 24'hffffff, 24'h300000);
		rc(8'h17, 24'hffffff, 24'h300000);
		rc(8'h1a, 24'hffffff, 24'h200000);
		rc(8'h19, 24'hffffff, 24'h000000);
		rc(8'h18, 24'hffffff, 24'h300000);
		rc(8'h17, 24'hffffff, 24'h000000);
		CORE.wr(8'hde, 24'h0000ff);
		settle();
		chk(eirq, 24'h0);
		// ****************************************
		// crossing, period and frequency
		// ****************************************
		CORE.wr(8'h11, 24'h000fff);
		CORE.wr(8'hdb, 24'h000001);
		cyc(24'sh0c0000, 500, 3);
		chk(eirq, 24'h1);
		rc(8'hde, 24'h000001, 24'h000001);
		CORE.wr(8'h30, 24'h000001);
		CORE.wr(8'h0c, 24'h000000);
		cyc(24'sh0c0000, 500, 3);
		CORE.rd(8'h0a, d);
		chk(d >= 24'd99 && d <= 24'd101, 24'h1);
		CORE.wr(8'h0c, 24'h000002);
		// 2000-clock line: count 199..200, so 6553600 / count fits in 16 bits
		cyc(24'sh0c0000, 1000, 2);
		CORE.rd(8'h0a, d);
		chk(d >= 24'd32604 && d <= 24'd32932, 24'h1);
		// ****************************************
		// crossing timeout: 4 ticks of 160 clocks
		// ****************************************
		CORE.wr(8'h11, 24'h000004);
		CORE.wr(8'hdb, 24'h000002);
		CORE.wr(8'hde, 24'h0000ff);
		cyc(24'sh0c0000, 200, 3);
		men <= 1'b0;
		rc(8'hde, 24'h000002, 24'h000000);
		// no metering enable, so the timeout must not move
		repeat (800) @(posedge clk);
		rc(8'hde, 24'h000002, 24'h000000);
		@(posedge clk);
		men <= 1'b1;
		repeat (700) @(posedge clk);
		#1;
		chk(eirq, 24'h1);
		rc(8'hde, 24'h000002, 24'h000002);
		CORE.wr(8'hde, 24'h0000ff);
		settle();
		chk(eirq, 24'h0);
		// ****************************************
		// sag detection
		// ****************************************
		CORE.wr(8'h11, 24'h000fff);
		CORE.wr(8'h14, 24'h000001);
		CORE.wr(8'h13, 24'h000004);
		CORE.wr(8'hec, 24'h000020);
		cyc(24'sh000100, 200, 5);
		chk(pirq, 24'h0);
		rc(8'hf8, 24'h000020, 24'h000000);
		CORE.wr(8'h14, 24'h001000);
		cyc(24'sh200000, 200, 1);
		cyc(24'sh080000, 200, 3);
		rc(8'hf8, 24'h000020, 24'h000000);
		cyc(24'sh080000, 200, 1);
		chk(pirq, 24'h1);
		rc(8'hf8, 24'h000020, 24'h000020);
		CORE.wr(8'hf8, 24'h0000ff);
		settle();
		chk(pirq, 24'h0);
		end_of_test();
	end
endmodule

bind lpqm_top lpqm_top_assertions CHK (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
	.metering_clk_en_i(metering_clk_en_i), .voltage_valid_i(voltage_valid_i), .current_valid_i(current_valid_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.energy_irq_o(energy_irq_o), .power_mgmt_irq_o(power_mgmt_irq_o), .line_crossing_o(line_crossing_o));
